// ===== inc/fsa_pkg.sv
// Shared constants and carrier types for the fieldbus slave addressing block
package fsa_pkg;
	localparam logic [6:0] ADDR_DEFAULT = 7'h7e;
	localparam logic [6:0] ADDR_RESERVED_LO = 7'h00;
	localparam logic [6:0] ADDR_MAX_VALID = 7'h7d;
	localparam int CLK_HZ = 20000000;
	localparam int PLUG_HOLD_MS = 3000;
	localparam int PLUG_HOLD_CYC = (CLK_HZ / 1000) * PLUG_HOLD_MS;
	localparam int FLASH_MS = 250;
	localparam int FLASH_CYC = (CLK_HZ / 1000) * FLASH_MS;
	localparam int FLASH_TOGGLES = 8;
	localparam logic [3:0] LAYOUT1_VALUES = 4'h4;
	localparam logic [3:0] LAYOUT2_VALUES = 4'h8;
	localparam logic [3:0] LAYOUT3_VALUES = 4'he;
	localparam int VALUE_W = 16;
	localparam int FIFO_DEPTH = 32;

	typedef enum logic [1:0] {
		FSA_SRC_NONE = 2'b00,
		FSA_SRC_C1 = 2'b01,
		FSA_SRC_C2 = 2'b10
	} fsa_src_t;

	// Acyclic data-set request from a master
	typedef struct packed {
		fsa_src_t src;
		logic write;
		logic [7:0] index;
		logic [15:0] data;
	} fsa_acyc_req_t;

	// Acyclic answer back to the master
	typedef struct packed {
		fsa_src_t src;
		logic [7:0] index;
		logic [15:0] data;
	} fsa_acyc_rsp_t;

	// Address change request
	typedef struct packed {
		logic from_c2;
		logic [6:0] addr;
	} fsa_addr_req_t;
endpackage

// ===== verilog/fsa_fifo.sv
// Parameterised flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module fsa_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic flush_i
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic push, pop;

	// Handshakes; full and empty come from the count
	assign in_ready_o = (cnt_r != DEPTH[AW:0]);
	assign out_valid_o = (cnt_r != '0);
	assign out_data_o = mem_r[rp_r];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	// Pointer and count update
	always_comb
	begin
		wp_nxt = push ? wp_r + 1'b1 : wp_r;
		rp_nxt = pop ? rp_r + 1'b1 : rp_r;
		cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		if (flush_i)
		begin
			wp_nxt = '0;
			rp_nxt = '0;
			cnt_nxt = '0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end
		else
		begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// Storage needs no reset; only written slots are ever read
	always_ff @(posedge clk_i)
	begin
		if (push)
			mem_r[wp_r] <= in_data_i;
	end
endmodule
`default_nettype wire

// ===== verilog/fsa_layout_map.sv
// Cyclic layout table: entry count per preset layout and one value selector per slot, shared by all layouts
`timescale 1ns/1ps
`default_nettype none
module fsa_layout_map #(
	parameter int MAX_ENTRIES = 14
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic subst_we_i,
	input wire logic [3:0] subst_slot_i,
	input wire logic [7:0] subst_qty_i,
	input wire logic [1:0] layout_i,
	input wire logic [3:0] slot_i,
	output logic [3:0] count_o,
	output logic [7:0] qty_o,
	output logic layout_ok_o
);
	logic [7:0] qty_r [MAX_ENTRIES];

	// Entry count for each preset
	always_comb
	begin
		case (layout_i)
			2'd1: count_o = fsa_pkg::LAYOUT1_VALUES;
			2'd2: count_o = fsa_pkg::LAYOUT2_VALUES;
			2'd3: count_o = fsa_pkg::LAYOUT3_VALUES;
			default: count_o = 4'h0;
		endcase
	end
	assign layout_ok_o = (layout_i != 2'd0);
	assign qty_o = (slot_i < 4'(MAX_ENTRIES)) ? qty_r[slot_i] : 8'h00;

	// Entries default to quantity id equal to slot; any may be replaced
	generate
		for (genvar g = 0; g < MAX_ENTRIES; g++)
		begin : g_slot
			always_ff @(posedge clk_i or negedge rst_n_i)
			begin
				if (!rst_n_i)
					qty_r[g] <= 8'(g);
				else if (subst_we_i && subst_slot_i == 4'(g))
					qty_r[g] <= subst_qty_i;
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ===== verilog/fsa_slave.sv
// Fieldbus slave: address store, adoption, cyclic layout and acyclic service
`timescale 1ns/1ps
`default_nettype none
module fsa_slave #(
	parameter bit IMMEDIATE = 1'b1,
	parameter int PLUG_HOLD_CYC = fsa_pkg::PLUG_HOLD_CYC,
	parameter int FLASH_CYC = fsa_pkg::FLASH_CYC,
	parameter int FIFO_DEPTH = fsa_pkg::FIFO_DEPTH
) (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic [6:0] frame_addr_i,
	input wire logic frame_valid_i,
	input wire fsa_pkg::fsa_src_t frame_src_i,
	input wire logic cfg_valid_i,
	input wire logic [1:0] cfg_layout_i,
	input wire logic cyc_stop_i,
	input wire logic addr_req_valid_i,
	input wire fsa_pkg::fsa_addr_req_t addr_req_i,
	input wire logic bus_write_permit_jumper_i,
	input wire logic supply_restored_i,
	input wire logic plug_present_i,
	input wire logic [6:0] plug_addr_i,
	input wire logic service_button_i,
	input wire logic subst_we_i,
	input wire logic [3:0] subst_slot_i,
	input wire logic [7:0] subst_qty_i,
	input wire logic [fsa_pkg::VALUE_W-1:0] value_data_i,
	input wire logic acyc_valid_i,
	input wire fsa_pkg::fsa_acyc_req_t acyc_req_i,
	output logic acyc_ready_o,
	output logic rsp_valid_o,
	output fsa_pkg::fsa_acyc_rsp_t rsp_o,
	input wire logic rsp_ready_i,
	output logic cyc_valid_o,
	output logic [fsa_pkg::VALUE_W-1:0] cyc_data_o,
	input wire logic cyc_ready_i,
	output logic [7:0] cyc_qty_o,
	output logic addr_match_o,
	output logic [6:0] active_addr_o,
	output logic [6:0] stored_addr_o,
	output logic cyc_active_o,
	output logic [1:0] layout_o,
	output logic addr_reject_o,
	output logic status_led_o
);
	typedef enum logic [1:0] {
		FSA_LED_IDLE = 2'b00,
		FSA_LED_FLASH = 2'b01
	} fsa_led_t;

	logic rst_s1_r, rst_n;
	logic [6:0] active_r, active_nxt, stored_r, stored_nxt;
	logic cyc_r, cyc_nxt;
	logic [1:0] layout_r, layout_nxt;
	logic match_r, match_nxt, rej_r, rej_nxt;
	logic [3:0] slot_r, slot_nxt;
	logic [31:0] hold_r, hold_nxt;
	logic plug_done;
	fsa_led_t led_st_r, led_st_nxt;
	logic [31:0] flash_r, flash_nxt;
	logic [3:0] tog_r, tog_nxt;
	logic led_r, led_nxt;
	logic rv_r, rv_nxt, rdy_r, rdy_nxt;
	fsa_pkg::fsa_acyc_rsp_t rsp_r, rsp_nxt;
	logic [fsa_pkg::VALUE_W-1:0] ds_r [256];
	logic [3:0] lay_cnt;
	logic [7:0] lay_qty;
	logic lay_ok, req_ok, write_allowed, c1_cyc_cfg;
	logic fifo_in_ready, fifo_push;

	// Reset release through two flops
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			rst_s1_r <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_s1_r <= 1'b1;
			rst_n <= rst_s1_r;
		end
	end

	fsa_layout_map #(
		.MAX_ENTRIES(14)
	) u_map (
		.clk_i(mclk_i),
		.rst_n_i(rst_n),
		.subst_we_i(subst_we_i),
		.subst_slot_i(subst_slot_i),
		.subst_qty_i(subst_qty_i),
		.layout_i(cfg_valid_i ? cfg_layout_i : layout_r),
		.slot_i(slot_r),
		.count_o(lay_cnt),
		.qty_o(lay_qty),
		.layout_ok_o(lay_ok)
	);

	// Range check on a requested address; 0, 126 and above 125 are refused
	assign req_ok = (addr_req_i.addr != fsa_pkg::ADDR_RESERVED_LO)
		&& (addr_req_i.addr <= fsa_pkg::ADDR_MAX_VALID);
	// Deferred variant guards bus writes with the jumper
	assign write_allowed = IMMEDIATE || bus_write_permit_jumper_i;
	assign c1_cyc_cfg = cfg_valid_i && frame_src_i == fsa_pkg::FSA_SRC_C1 && lay_ok;
	assign plug_done = IMMEDIATE && plug_present_i && hold_r == 32'(PLUG_HOLD_CYC - 1);

	// Address store, adoption and cyclic session state
	always_comb
	begin
		active_nxt = active_r;
		stored_nxt = stored_r;
		cyc_nxt = cyc_r;
		layout_nxt = layout_r;
		rej_nxt = 1'b0;
		hold_nxt = (service_button_i && plug_present_i && hold_r != 32'(PLUG_HOLD_CYC)) ? hold_r + 32'd1
			: (service_button_i ? hold_r : 32'd0);
		// Only the class 1 master may start cyclic exchange
		if (c1_cyc_cfg)
		begin
			cyc_nxt = 1'b1;
			layout_nxt = cfg_layout_i;
		end
		if (cyc_stop_i)
			cyc_nxt = 1'b0;
		// Set-address service works in both variants
		if (addr_req_valid_i)
		begin
			if (!req_ok || !write_allowed)
				rej_nxt = 1'b1;
			else
			begin
				stored_nxt = addr_req_i.addr;
				if (IMMEDIATE && !cyc_r)
				begin
					active_nxt = addr_req_i.addr;
					cyc_nxt = 1'b0;
				end
			end
		end
		// Immediate variant loads the addressing plug after the hold time
		if (plug_done)
		begin
			if (plug_addr_i != fsa_pkg::ADDR_RESERVED_LO && plug_addr_i <= fsa_pkg::ADDR_MAX_VALID)
			begin
				stored_nxt = plug_addr_i;
				active_nxt = plug_addr_i;
				cyc_nxt = 1'b0;
			end
			else
				rej_nxt = 1'b1;
		end
		// In the deferred variant supply restore adopts what was stored
		if (!IMMEDIATE && supply_restored_i)
		begin
			active_nxt = stored_r;
			cyc_nxt = 1'b0;
		end
	end

	// Frame address filter; stale address is never answered after a change
	always_comb
	begin
		match_nxt = frame_valid_i && frame_addr_i == active_r;
	end

	always_ff @(posedge mclk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			active_r <= fsa_pkg::ADDR_DEFAULT;
			stored_r <= fsa_pkg::ADDR_DEFAULT;
			cyc_r <= 1'b0;
			layout_r <= 2'd1;
			rej_r <= 1'b0;
			hold_r <= 32'd0;
			match_r <= 1'b0;
		end
		else
		begin
			active_r <= active_nxt;
			stored_r <= stored_nxt;
			cyc_r <= cyc_nxt;
			layout_r <= layout_nxt;
			rej_r <= rej_nxt;
			hold_r <= hold_nxt;
			match_r <= match_nxt;
		end
	end

	// Status indicator: flash burst after plug transfer, steady while cyclic
	always_comb
	begin
		led_st_nxt = led_st_r;
		flash_nxt = flash_r;
		tog_nxt = tog_r;
		led_nxt = cyc_r;
		case (led_st_r)
			FSA_LED_IDLE:
			begin
				if (plug_done)
				begin
					led_st_nxt = FSA_LED_FLASH;
					flash_nxt = 32'd0;
					tog_nxt = 4'd0;
					led_nxt = 1'b1;
				end
			end
			FSA_LED_FLASH:
			begin
				led_nxt = led_r;
				if (flash_r == 32'(FLASH_CYC - 1))
				begin
					flash_nxt = 32'd0;
					led_nxt = ~led_r;
					tog_nxt = tog_r + 4'd1;
					if (tog_r == 4'(fsa_pkg::FLASH_TOGGLES - 1))
						led_st_nxt = FSA_LED_IDLE;
				end
				else
					flash_nxt = flash_r + 32'd1;
			end
			default: led_st_nxt = FSA_LED_IDLE;
		endcase
	end

	always_ff @(posedge mclk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			led_st_r <= FSA_LED_IDLE;
			flash_r <= 32'd0;
			tog_r <= 4'd0;
			led_r <= 1'b0;
		end
		else
		begin
			led_st_r <= led_st_nxt;
			flash_r <= flash_nxt;
			tog_r <= tog_nxt;
			led_r <= led_nxt;
		end
	end

	// Cyclic slot walk feeds the FIFO; stalls when the FIFO is full
	assign fifo_push = cyc_r && match_r;
	always_comb
	begin
		slot_nxt = slot_r;
		// Restart the walk on a new configuration so a smaller layout never sees a stale slot
		if (!cyc_r || c1_cyc_cfg)
			slot_nxt = 4'd0;
		else if (fifo_push && fifo_in_ready)
			slot_nxt = (slot_r == lay_cnt - 4'd1) ? 4'd0 : slot_r + 4'd1;
	end

	always_ff @(posedge mclk_i or negedge rst_n)
	begin
		if (!rst_n)
			slot_r <= 4'd0;
		else
			slot_r <= slot_nxt;
	end

	// Output FIFO decouples value production from bus pacing
	fsa_fifo #(
		.WIDTH(fsa_pkg::VALUE_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(mclk_i),
		.rst_n_i(rst_n),
		.in_valid_i(fifo_push),
		.in_ready_o(fifo_in_ready),
		.in_data_i(value_data_i),
		.out_valid_o(cyc_valid_o),
		.out_ready_i(cyc_ready_i),
		.out_data_o(cyc_data_o),
		.flush_i(!cyc_r)
	);

	// Acyclic data sets from either master class; one answer held at a time
	// Ready has its own flop so the port stays free of logic
	assign acyc_ready_o = rdy_r;
	always_comb
	begin
		rv_nxt = rv_r;
		rsp_nxt = rsp_r;
		if (rv_r && rsp_ready_i)
			rv_nxt = 1'b0;
		if (acyc_valid_i && !rv_r && acyc_req_i.src != fsa_pkg::FSA_SRC_NONE)
		begin
			rv_nxt = 1'b1;
			rsp_nxt.src = acyc_req_i.src;
			rsp_nxt.index = acyc_req_i.index;
			rsp_nxt.data = acyc_req_i.write ? acyc_req_i.data : ds_r[acyc_req_i.index];
		end
		rdy_nxt = !rv_nxt;
	end

	always_ff @(posedge mclk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rv_r <= 1'b0;
			rdy_r <= 1'b1;
			rsp_r <= '0;
		end
		else
		begin
			rv_r <= rv_nxt;
			rdy_r <= rdy_nxt;
			rsp_r <= rsp_nxt;
		end
	end

	// Data-set store; deferred variant honours the jumper on writes
	always_ff @(posedge mclk_i)
	begin
		if (acyc_valid_i && !rv_r && acyc_req_i.write && write_allowed)
			ds_r[acyc_req_i.index] <= acyc_req_i.data;
	end

	// Registered status outputs
	always_ff @(posedge mclk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			active_addr_o <= fsa_pkg::ADDR_DEFAULT;
			stored_addr_o <= fsa_pkg::ADDR_DEFAULT;
			cyc_active_o <= 1'b0;
			layout_o <= 2'd1;
			addr_reject_o <= 1'b0;
			status_led_o <= 1'b0;
			addr_match_o <= 1'b0;
			cyc_qty_o <= 8'h00;
		end
		else
		begin
			active_addr_o <= active_r;
			stored_addr_o <= stored_r;
			cyc_active_o <= cyc_r;
			layout_o <= layout_r;
			addr_reject_o <= rej_r;
			status_led_o <= led_r;
			addr_match_o <= match_r;
			cyc_qty_o <= lay_qty;
		end
	end
	assign rsp_valid_o = rv_r;
	assign rsp_o = rsp_r;

	a_reject_keeps_addr: assert property (@(posedge mclk_i) disable iff (!rst_n)
		addr_req_valid_i && !req_ok |=> active_r == $past(active_r) && rej_r)
		else $error("bad address adopted");
	a_default_addr: assert property (@(posedge mclk_i) disable iff (!rst_n)
		$rose(rst_n) |-> active_r == fsa_pkg::ADDR_DEFAULT)
		else $error("reset address not default");
	a_immediate_adopt: assert property (@(posedge mclk_i) disable iff (!rst_n)
		IMMEDIATE && addr_req_valid_i && req_ok && !cyc_r && !plug_done |=> active_r == $past(addr_req_i.addr))
		else $error("address not adopted");
	a_deferred_hold: assert property (@(posedge mclk_i) disable iff (!rst_n)
		!IMMEDIATE && !supply_restored_i |=> active_r == $past(active_r))
		else $error("deferred address moved early");
	a_jumper_guard: assert property (@(posedge mclk_i) disable iff (!rst_n)
		!IMMEDIATE && addr_req_valid_i && !bus_write_permit_jumper_i && !supply_restored_i
		|=> stored_r == $past(stored_r))
		else $error("write without jumper");
	a_c1_only_cyclic: assert property (@(posedge mclk_i) disable iff (!rst_n)
		!cyc_r && cfg_valid_i && frame_src_i != fsa_pkg::FSA_SRC_C1 |=> !cyc_r)
		else $error("cyclic started by non class 1");
	a_slot_bound: assert property (@(posedge mclk_i) disable iff (!rst_n)
		cyc_r |-> slot_r < lay_cnt)
		else $error("slot beyond layout");
	a_acyc_answer: assert property (@(posedge mclk_i) disable iff (!rst_n)
		acyc_valid_i && acyc_ready_o && acyc_req_i.src != fsa_pkg::FSA_SRC_NONE
		|=> rv_r && rsp_r.src == $past(acyc_req_i.src))
		else $error("acyclic request unanswered");
	a_match_new: assert property (@(posedge mclk_i) disable iff (!rst_n)
		frame_valid_i && frame_addr_i != active_r |=> !match_r)
		else $error("old address answered");
	// Flash burst opens with the indicator lit
	sequence s_flash_start;
		led_st_r == FSA_LED_FLASH ##1 led_r;
	endsequence
	a_plug_flash: assert property (@(posedge mclk_i) disable iff (!rst_n)
		plug_done && led_st_r == FSA_LED_IDLE |=> s_flash_start)
		else $error("no flash after plug load");
endmodule
`default_nettype wire

// ===== dv/fsa_master_model.sv
// Fieldbus master model issuing acyclic data-set requests
`timescale 1ns/1ps
`default_nettype none
module fsa_master_model (
	input wire logic clk_i,
	input wire logic acyc_ready_i,
	input wire logic rsp_valid_i,
	input wire fsa_pkg::fsa_acyc_rsp_t rsp_i,
	output logic acyc_valid_o,
	output fsa_pkg::fsa_acyc_req_t acyc_req_o,
	output logic rsp_ready_o
);
	// Idle until the bench asks for a transfer
	initial
	begin
		acyc_valid_o = 1'b0;
		acyc_req_o = '0;
		rsp_ready_o = 1'b0;
	end

	// One data-set transfer from class 1 or class 2; stall holds off the answer
	task automatic xfer(input fsa_pkg::fsa_acyc_req_t req, input int stall,
		output fsa_pkg::fsa_acyc_rsp_t rsp, output bit ok);
		int n;
		n = 0;
		acyc_valid_o = 1'b1;
		acyc_req_o = req;
		@(posedge clk_i);
		while (acyc_ready_i !== 1'b1 && n < 20)
		begin
			n++;
			@(posedge clk_i);
		end
		#1;
		// Released request lines stop showing the old value
		acyc_valid_o = 1'b0;
		acyc_req_o = ~req;
		repeat (stall) @(posedge clk_i);
		if (stall > 0)
			#1;
		rsp_ready_o = 1'b1;
		@(posedge clk_i);
		while (rsp_valid_i !== 1'b1 && n < 40)
		begin
			n++;
			@(posedge clk_i);
		end
		rsp = rsp_i;
		ok = (n < 40);
		#1;
		rsp_ready_o = 1'b0;
	endtask
endmodule
`default_nettype wire

// ===== dv/tb_fsa_slave.sv
// Self-checking testbench for the fieldbus slave addressing block
`timescale 1ns/1ps
`default_nettype none
module tb_fsa_slave;
	localparam int HOLD = 20;
	localparam int FLASH = 4;
	logic mclk_i, resetn_i, frame_valid_i, cfg_valid_i, cyc_stop_i, addr_req_valid_i;
	logic bus_write_permit_jumper_i, supply_restored_i, plug_present_i, service_button_i;
	logic subst_we_i, acyc_valid_i, acyc_ready_o, rsp_valid_o, rsp_ready_i, cyc_valid_o, cyc_ready_i;
	logic addr_match_o, cyc_active_o, addr_reject_o, status_led_o, d_reject, d_match, rej_seen, drej_seen;
	logic [6:0] frame_addr_i, plug_addr_i, active_addr_o, stored_addr_o, d_active, d_stored;
	logic [1:0] cfg_layout_i, layout_o;
	logic [3:0] subst_slot_i;
	logic [7:0] subst_qty_i, cyc_qty_o;
	logic [15:0] value_data_i, cyc_data_o;
	fsa_pkg::fsa_src_t frame_src_i;
	fsa_pkg::fsa_addr_req_t addr_req_i;
	fsa_pkg::fsa_acyc_req_t acyc_req_i;
	fsa_pkg::fsa_acyc_rsp_t rsp_o;
	int miscompares = 0;
	int n_checks = 0;

	// Immediate variant under test
	fsa_slave #(.IMMEDIATE(1'b1), .PLUG_HOLD_CYC(HOLD), .FLASH_CYC(FLASH), .FIFO_DEPTH(32)) dut (.mclk_i,
		.resetn_i, .frame_addr_i, .frame_valid_i, .frame_src_i, .cfg_valid_i, .cfg_layout_i, .cyc_stop_i,
		.addr_req_valid_i, .addr_req_i, .bus_write_permit_jumper_i, .supply_restored_i, .plug_present_i,
		.plug_addr_i, .service_button_i, .subst_we_i, .subst_slot_i, .subst_qty_i, .value_data_i, .acyc_valid_i,
		.acyc_req_i, .acyc_ready_o, .rsp_valid_o, .rsp_o, .rsp_ready_i, .cyc_valid_o, .cyc_data_o, .cyc_ready_i,
		.cyc_qty_o, .addr_match_o, .active_addr_o, .stored_addr_o, .cyc_active_o, .layout_o, .addr_reject_o,
		.status_led_o);
	// Deferred variant sharing all stimulus; only its address side is judged
	fsa_slave #(.IMMEDIATE(1'b0), .PLUG_HOLD_CYC(HOLD), .FLASH_CYC(FLASH), .FIFO_DEPTH(32)) dut_def (.mclk_i,
		.resetn_i, .frame_addr_i, .frame_valid_i, .frame_src_i, .cfg_valid_i, .cfg_layout_i, .cyc_stop_i,
		.addr_req_valid_i, .addr_req_i, .bus_write_permit_jumper_i, .supply_restored_i, .plug_present_i,
		.plug_addr_i, .service_button_i, .subst_we_i, .subst_slot_i, .subst_qty_i, .value_data_i, .acyc_valid_i,
		.acyc_req_i, .acyc_ready_o(), .rsp_valid_o(), .rsp_o(), .rsp_ready_i, .cyc_valid_o(), .cyc_data_o(),
		.cyc_ready_i, .cyc_qty_o(), .addr_match_o(d_match), .active_addr_o(d_active), .stored_addr_o(d_stored),
		.cyc_active_o(), .layout_o(), .addr_reject_o(d_reject), .status_led_o());
	fsa_master_model master (.clk_i(mclk_i), .acyc_ready_i(acyc_ready_o), .rsp_valid_i(rsp_valid_o),
		.rsp_i(rsp_o), .acyc_valid_o(acyc_valid_i), .acyc_req_o(acyc_req_i), .rsp_ready_o(rsp_ready_i));

	// 20 MHz clock
	initial
	begin
		mclk_i = 1'b0;
		forever #25 mclk_i = ~mclk_i;
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Every drive happens 1 ns after a rising edge
	task automatic tick();
		@(posedge mclk_i);
		#1;
	endtask

	// Address write; the one-cycle reject pulse is caught while it stands
	task automatic addr_write(input logic [6:0] a, input logic c2);
		addr_req_valid_i = 1'b1;
		addr_req_i = '{c2, a};
		tick();
		addr_req_valid_i = 1'b0;
		addr_req_i = ~addr_req_i;
		tick();
		rej_seen = addr_reject_o;
		drej_seen = d_reject;
		tick();
	endtask

	// Single frame; the match may land on either of the next two edges
	task automatic frame(input logic [6:0] a, input logic exp);
		logic seen;
		frame_addr_i = a;
		frame_valid_i = 1'b1;
		tick();
		frame_valid_i = 1'b0;
		tick();
		seen = addr_match_o;
		tick();
		chk("addr_match", seen | addr_match_o, exp);
	endtask

	task automatic cfg(input logic [1:0] l, input fsa_pkg::fsa_src_t s);
		frame_src_i = s;
		cfg_layout_i = l;
		cfg_valid_i = 1'b1;
		tick();
		cfg_valid_i = 1'b0;
		frame_src_i = fsa_pkg::FSA_SRC_C1;
		repeat (2) tick();
	endtask

	// Back-to-back class 1 frames at the active address
	task automatic frames(input int n);
		frame_addr_i = 7'h21;
		frame_valid_i = 1'b1;
		repeat (n) tick();
		frame_valid_i = 1'b0;
		repeat (6) tick();
	endtask

	task automatic stop_cyc();
		cyc_stop_i = 1'b1;
		tick();
		cyc_stop_i = 1'b0;
		repeat (3) tick();
		chk("cyc_active off", cyc_active_o, 1'b0);
	endtask

	task automatic t_reset();
		chk("active", active_addr_o, 7'h7e);
		chk("stored", stored_addr_o, 7'h7e);
		chk("layout", layout_o, 2'h1);
	endtask

	// Legal addresses only; the jumper is off so the deferred copy refuses
	task automatic t_addr_imm();
		addr_write(7'h05, 1'b1);
		chk("active", active_addr_o, 7'h05);
		chk("reject", rej_seen, 1'b0);
		chk("def reject", drej_seen, 1'b1);
		chk("def stored", d_stored, 7'h7e);
		frame(7'h05, 1'b1);
		frame(7'h7e, 1'b0);
		addr_write(7'h07, 1'b0);
		chk("active", active_addr_o, 7'h07);
	endtask

	task automatic t_reject();
		logic [6:0] bad [3] = '{7'h00, 7'h7e, 7'h7f};
		foreach (bad[i])
		begin
			addr_write(bad[i], 1'b1);
			chk("reject", rej_seen, 1'b1);
			chk("active kept", active_addr_o, 7'h07);
		end
	endtask

	task automatic t_deferred();
		bus_write_permit_jumper_i = 1'b1;
		addr_write(7'h21, 1'b1);
		chk("def stored", d_stored, 7'h21);
		chk("def reject", drej_seen, 1'b0);
		chk("def active", d_active, 7'h7e);
		supply_restored_i = 1'b1;
		tick();
		supply_restored_i = 1'b0;
		repeat (3) tick();
		chk("def active", d_active, 7'h21);
	endtask

	task automatic t_layouts();
		int nv [3] = '{4, 8, 14};
		for (int l = 1; l <= 3; l++)
		begin
			cfg(l[1:0], fsa_pkg::FSA_SRC_C1);
			chk("cyc_active", cyc_active_o, 1'b1);
			chk("layout", layout_o, l);
			frames(nv[l - 1] - 1);
			chk("qty last", cyc_qty_o, nv[l - 1] - 1);
			frames(1);
			chk("qty wrap", cyc_qty_o, 8'h00);
			stop_cyc();
		end
		cfg(2'h2, fsa_pkg::FSA_SRC_C2);
		chk("c2 cfg", cyc_active_o, 1'b0);
		cfg(2'h0, fsa_pkg::FSA_SRC_C1);
		chk("layout 0", cyc_active_o, 1'b0);
	endtask

	// Substitution, deferred address while cyclic, then fill and drain
	task automatic t_subst_fifo();
		int cnt;
		logic bad;
		cnt = 0;
		bad = 1'b0;
		subst_slot_i = 4'h0;
		subst_qty_i = 8'h55;
		subst_we_i = 1'b1;
		tick();
		subst_we_i = 1'b0;
		tick();
		cfg(2'h1, fsa_pkg::FSA_SRC_C1);
		chk("subst qty", cyc_qty_o, 8'h55);
		addr_write(7'h28, 1'b0);
		chk("stored", stored_addr_o, 7'h28);
		chk("active kept", active_addr_o, 7'h21);
		value_data_i = 16'hbeef;
		frames(40);
		cyc_ready_i = 1'b1;
		// Judge the settled outputs that the next edge will pop
		repeat (50)
		begin
			if (cyc_valid_o === 1'b1)
			begin
				cnt++;
				bad |= (cyc_data_o !== 16'hbeef);
			end
			tick();
		end
		cyc_ready_i = 1'b0;
		chk("fifo count", cnt, 32);
		chk("fifo data bad", bad, 1'b0);
		stop_cyc();
	endtask

	task automatic t_acyc();
		fsa_pkg::fsa_acyc_rsp_t r;
		bit ok;
		master.xfer('{fsa_pkg::FSA_SRC_C1, 1'b1, 8'h03, 16'h1234}, 0, r, ok);
		chk("c1 wr", {ok, r.src, r.data}, {1'b1, fsa_pkg::FSA_SRC_C1, 16'h1234});
		master.xfer('{fsa_pkg::FSA_SRC_C1, 1'b0, 8'h03, 16'h0000}, 0, r, ok);
		chk("c1 rd", {ok, r.index, r.data}, {1'b1, 8'h03, 16'h1234});
		master.xfer('{fsa_pkg::FSA_SRC_C2, 1'b1, 8'h04, 16'habcd}, 3, r, ok);
		master.xfer('{fsa_pkg::FSA_SRC_C2, 1'b0, 8'h04, 16'h0000}, 3, r, ok);
		chk("c2 rd", {ok, r.src, r.data}, {1'b1, fsa_pkg::FSA_SRC_C2, 16'habcd});
	endtask

	task automatic t_plug();
		int tog;
		logic last;
		tog = 0;
		last = status_led_o;
		plug_present_i = 1'b1;
		plug_addr_i = 7'h09;
		service_button_i = 1'b1;
		for (int i = 0; i < HOLD + 40 + FLASH * 8; i++)
		begin
			if (i == HOLD + 10)
			begin
				service_button_i = 1'b0;
				plug_present_i = 1'b0;
				plug_addr_i = 7'h76;
			end
			tick();
			if (i == HOLD - 1)
				chk("plug early", active_addr_o, 7'h21);
			tog += (status_led_o !== last);
			last = status_led_o;
		end
		chk("plug addr", active_addr_o, 7'h09);
		// Lit on entry, the burst's toggles, then back to steady off
		chk("led toggles", tog, fsa_pkg::FLASH_TOGGLES + 2);
	endtask

	// Watchdog well beyond the expected run
	initial
	begin
		#2000000;
		miscompares++;
		report_and_stop();
	end

	// Reset, then scenarios in order
	initial
	begin
		{frame_valid_i, cfg_valid_i, cyc_stop_i, addr_req_valid_i, bus_write_permit_jumper_i} = '0;
		{supply_restored_i, plug_present_i, service_button_i, subst_we_i, cyc_ready_i} = '0;
		{frame_addr_i, plug_addr_i, cfg_layout_i, subst_slot_i, subst_qty_i, value_data_i} = '0;
		frame_src_i = fsa_pkg::FSA_SRC_C1;
		addr_req_i = '0;
		resetn_i = 1'b0;
		repeat (3) @(posedge mclk_i);
		#1;
		resetn_i = 1'b1;
		repeat (4) tick();
		t_reset();
		t_addr_imm();
		t_reject();
		t_deferred();
		t_layouts();
		t_subst_fifo();
		t_acyc();
		t_plug();
		report_and_stop();
	end
endmodule
`default_nettype wire
